//--- pkg/udc_pkg.sv
// shared constants and types for the up/down threshold counter
package udc_pkg;
    // register bus geometry
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;

    // register byte offsets
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_START  = 8'h04;
    localparam logic [7:0] OFS_SET    = 8'h08;
    localparam logic [7:0] OFS_CLEAR  = 8'h0C;
    localparam logic [7:0] OFS_COUNT  = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;

    // control field positions
    localparam int unsigned CTRL_SET_EXT_BIT = 0;
    localparam int unsigned CTRL_CLR_EXT_BIT = 1;

    // status field positions
    localparam int unsigned STAT_SWITCH_BIT = 0;
    localparam int unsigned STAT_WIPE_BIT   = 1;
    localparam int unsigned STAT_DIR_BIT    = 2;

    // reset values
    localparam logic [31:0] RST_START = 32'h0000_0000;
    localparam logic [31:0] RST_SET   = 32'h0000_0000;
    localparam logic [31:0] RST_CLEAR = 32'h0000_0000;
    localparam logic [31:0] RST_COUNT = 32'h0000_0000;

    // default permitted count range
    localparam logic [31:0] DEF_CNT_MIN = 32'h0000_0000;
    localparam logic [31:0] DEF_CNT_MAX = 32'h000F_423F;

    // software configuration travelling as one group
    typedef struct packed {
        logic        set_ext;   // set level taken from another block
        logic        clr_ext;   // clear level taken from another block
        logic [31:0] start;     // value loaded by the wipe input
        logic [31:0] set_lvl;   // fixed set level
        logic [31:0] clr_lvl;   // fixed clear level
    } udc_cfg_s;
endpackage

//--- rtl/udc_counter.sv
// up/down event counter with set/clear threshold switch and register port
`timescale 1ns/100ps
// What this block does
// (R1) switch output turns on or off when the count reaches set or clear level
// (R2) each pulse rising edge counts one: up for direction 0, down for 1, holding at the range ends
// (R3) wipe input loads the count with the configured start value
// (R4) while wipe is high, switch output is 0 and pulse edges are ignored
// (R5) set and clear levels come from fixed settings or another block's value
// (R6) out-of-range levels from another block are clamped to nearest valid value
// (R7) pulse input sampled on the clock; each rising edge counted exactly once
module udc_counter
    import udc_pkg::*;
#(
    parameter logic [31:0] CNT_MIN = DEF_CNT_MIN,
    parameter logic [31:0] CNT_MAX = DEF_CNT_MAX
) (
    input  wire logic              i_mclk,       // system clock, 20 MHz
    input  wire logic              i_arst_n,     // async reset, active low
    input  wire logic              i_pulse,      // count pulse pin
    input  wire logic              i_dir,        // 0 up, 1 down
    input  wire logic              i_wipe,       // reload and hold
    input  wire logic [31:0]       i_ref_set,    // live set level from another block
    input  wire logic [31:0]       i_ref_clr,    // live clear level from another block
    input  wire logic [ADDR_W-1:0] i_addr,       // register byte address
    input  wire logic [DATA_W-1:0] i_wdata,      // write data
    input  wire logic              i_wr,         // write strobe
    input  wire logic              i_rd,         // read strobe
    output logic [DATA_W-1:0]      o_rdata,      // read data, cycle after strobe
    output logic [31:0]            o_count,      // actual value for other blocks
    output logic                   o_switch      // threshold switch output
);

    // clamp a value into the permitted range
    // unsigned compare; levels are counts and never negative
    function automatic logic [31:0] clamp(input logic [31:0] v);
        logic [31:0] r;
        r = v;
        if (v < CNT_MIN) begin
            r = CNT_MIN;
        end else if (v > CNT_MAX) begin
            r = CNT_MAX;
        end
        return r;
    endfunction

    udc_cfg_s    cfg;
    logic [31:0] count;
    logic        pulse_s1, pulse_s2, pulse_prev;
    logic        dir_s1, dir_s2;
    logic        wipe_s1, wipe_s2;

    // two-stage synchronisers; first stages feed only the second
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pulse_s1   <= 1'b0;
            pulse_s2   <= 1'b0;
            pulse_prev <= 1'b0;
            dir_s1     <= 1'b0;
            dir_s2     <= 1'b0;
            wipe_s1    <= 1'b0;
            wipe_s2    <= 1'b0;
        end else begin
            pulse_s1   <= i_pulse;
            pulse_s2   <= pulse_s1;
            pulse_prev <= pulse_s2;
            dir_s1     <= i_dir;
            dir_s2     <= dir_s1;
            wipe_s1    <= i_wipe;
            wipe_s2    <= wipe_s1;
        end
    end

    // edge detect on synchronised samples
    // prev resets low like the idle pin, so release brings no false edge
    wire         pulse_edge = pulse_s2 & ~pulse_prev; // R7

    // threshold selection and clamping
    wire  [31:0] set_raw = cfg.set_ext ? i_ref_set : cfg.set_lvl; // R5
    wire  [31:0] clr_raw = cfg.clr_ext ? i_ref_clr : cfg.clr_lvl; // R5
    wire  [31:0] set_c   = clamp(set_raw); // R6
    wire  [31:0] clr_c   = clamp(clr_raw); // R6
    wire  [31:0] start_c = clamp(cfg.start);

    // count step; saturates at range ends so it never wraps
    // wipe outranks a coincident edge; that edge is lost, never queued
    wire         at_max   = (count >= CNT_MAX);
    wire         at_min   = (count <= CNT_MIN);
    wire         step_up  = pulse_edge & ~wipe_s2 & ~dir_s2 & ~at_max; // R2
    wire         step_dn  = pulse_edge & ~wipe_s2 &  dir_s2 & ~at_min; // R2
    wire  [31:0] next_count = wipe_s2 ? start_c :                      // R3
                              step_up ? count + 32'h0000_0001 :
                              step_dn ? count - 32'h0000_0001 : count;

    // hysteresis when set >= clear, window otherwise
    wire         hyst     = (set_c >= clr_c);
    wire         on_cond  = hyst ? (count >= set_c) : (count >= set_c && count < clr_c); // R1
    wire         off_cond = hyst ? (count <  clr_c) : !(count >= set_c && count < clr_c); // R1
    wire         next_switch = wipe_s2  ? 1'b0 : // R4
                               on_cond  ? 1'b1 :
                               off_cond ? 1'b0 : o_switch;

    // counter and switch registers
    // both load every edge; holding is done in the next_ values
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count    <= RST_COUNT;
            o_switch <= 1'b0;
        end else begin
            count    <= next_count;
            o_switch <= next_switch;
        end
    end

    assign o_count = count;

    // register decode
    // exact byte match, so no word of the map aliases another
    wire         hit_ctrl  = (i_addr == OFS_CTRL);
    wire         hit_start = (i_addr == OFS_START);
    wire         hit_set   = (i_addr == OFS_SET);
    wire         hit_clear = (i_addr == OFS_CLEAR);
    wire         hit_count = (i_addr == OFS_COUNT);
    wire         hit_stat  = (i_addr == OFS_STATUS);
    wire  [31:0] ctrl_rd   = {30'h0, cfg.clr_ext, cfg.set_ext};
    wire  [31:0] stat_rd   = {29'h0, dir_s2, wipe_s2, o_switch};
    // unmapped addresses read as zero
    wire  [31:0] next_rdata = !i_rd     ? 32'h0000_0000 :
                              hit_ctrl  ? ctrl_rd :
                              hit_start ? cfg.start :
                              hit_set   ? cfg.set_lvl :
                              hit_clear ? cfg.clr_lvl :
                              hit_count ? count :
                              hit_stat  ? stat_rd : 32'h0000_0000;

    // configuration writes; writes to read-only or unmapped words are dropped
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cfg.set_ext <= 1'b0;
            cfg.clr_ext <= 1'b0;
            cfg.start   <= RST_START;
            cfg.set_lvl <= RST_SET;
            cfg.clr_lvl <= RST_CLEAR;
        end else if (i_wr) begin
            if (hit_ctrl) begin
                cfg.set_ext <= i_wdata[CTRL_SET_EXT_BIT];
                cfg.clr_ext <= i_wdata[CTRL_CLR_EXT_BIT];
            end
            if (hit_start) begin
                cfg.start <= i_wdata;
            end
            if (hit_set) begin
                cfg.set_lvl <= i_wdata;
            end
            if (hit_clear) begin
                cfg.clr_lvl <= i_wdata;
            end
        end
    end

    // read data register, zero outside the answer cycle
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 32'h0000_0000;
        end else begin
            o_rdata <= next_rdata;
        end
    end

    // up step lands one edge later
    count_up_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R2
        step_up |=> count == $past(count) + 32'h0000_0001)
        else $error("up count step wrong");

    // down step lands one edge later
    count_down_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R2
        step_dn |=> count == $past(count) - 32'h0000_0001)
        else $error("down count step wrong");

    // no edge, no wipe: count holds
    count_hold_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R2
        (!pulse_edge && !wipe_s2) |=> $stable(count))
        else $error("count moved without an edge");

    // wipe loads the start value
    wipe_load_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R3
        wipe_s2 |=> count == $past(start_c))
        else $error("wipe did not load start value");

    // switch forced off during wipe, two cycles held
    wipe_off_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R4
        wipe_s2 ##1 wipe_s2 |=> !o_switch && count == $past(start_c))
        else $error("switch or count active during wipe");

    // switch turns on only with its cause
    switch_on_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R1
        $rose(o_switch) |-> $past(on_cond) && !$past(wipe_s2))
        else $error("switch rose without reaching set level");

    // switch turns off only with its cause
    switch_off_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R1
        $fell(o_switch) |-> $past(off_cond) || $past(wipe_s2))
        else $error("switch fell without reaching clear level");

    // source selection follows the control bit
    set_source_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R5
        cfg.set_ext |-> set_raw == i_ref_set)
        else $error("set level source wrong");

    // clamped level sits at the nearest range end
    clamp_range_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R6
        (set_raw > CNT_MAX |-> set_c == CNT_MAX) and (clr_raw < CNT_MIN |-> clr_c == CNT_MIN))
        else $error("reference level not clamped");

    // a held-high pulse counts once only
    edge_once_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R7
        pulse_edge |=> !pulse_edge)
        else $error("one pulse edge seen twice");

    // helper for the wipe checks: cycles the synced wipe has stood high, saturating
    // narrow on purpose; it only has to tell a fresh wipe from a held one
    logic [3:0]  wipe_age;
    wire  [3:0]  next_wipe_age = !wipe_s2 ? 4'h0 :
                                 (wipe_age == 4'hF) ? wipe_age : wipe_age + 4'h1;

    // age register, checks only
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wipe_age <= 4'h0;
        end else begin
            wipe_age <= next_wipe_age;
        end
    end

    // synced wipe blocks both count steps
    wipe_block_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R4
        wipe_s2 |-> !step_up && !step_dn)
        else $error("count step taken during wipe");

    // switch stays low for as long as wipe has stood
    wipe_hold_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R4
        (wipe_age != 4'h0) |-> !o_switch)
        else $error("switch high while wipe held");

    // leaving wipe keeps the reloaded start value
    wipe_exit_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R3
        $fell(wipe_s2) |-> count == $past(start_c))
        else $error("count not at start value after wipe");

    // clear level source follows its control bit
    clear_source_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R5
        cfg.clr_ext |-> clr_raw == i_ref_clr)
        else $error("clear level source wrong");

    // fixed levels used when the control bits are clear
    fixed_source_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R5
        (!cfg.set_ext |-> set_raw == cfg.set_lvl) and (!cfg.clr_ext |-> clr_raw == cfg.clr_lvl))
        else $error("fixed level not used");

    // oversized clear level and undersized set level land on range ends
    clamp_high_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R6
        (clr_raw > CNT_MAX |-> clr_c == CNT_MAX) and (set_raw < CNT_MIN |-> set_c == CNT_MIN))
        else $error("level not clamped to range end");

    // in-range set level passes unchanged
    clamp_pass_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R6
        (set_raw >= CNT_MIN && set_raw <= CNT_MAX) |-> set_c == set_raw)
        else $error("in-range level altered");

    // count never passes the upper range end
    count_range_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R2
        count <= CNT_MAX)
        else $error("count above range");

    // up step at the ceiling is dropped, no wrap
    up_sat_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R2
        (pulse_edge && !wipe_s2 && !dir_s2 && at_max) |=> $stable(count))
        else $error("count wrapped at ceiling");

    // down step at the floor is dropped, no wrap
    down_sat_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R2
        (pulse_edge && !wipe_s2 && dir_s2 && at_min) |=> $stable(count))
        else $error("count wrapped at floor");

    // reaching the on condition turns the switch on next edge
    switch_set_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R1
        (on_cond && !wipe_s2) |=> o_switch)
        else $error("switch not on at set level");

    // meeting the off condition alone turns it off
    switch_clear_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R1
        (off_cond && !on_cond) |=> !o_switch)
        else $error("switch not off at clear level");

    // between the levels the switch keeps its state
    switch_hold_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R1
        (!on_cond && !off_cond && !wipe_s2) |=> $stable(o_switch))
        else $error("switch moved between levels");

    // an edge needs the synced pulse low one cycle earlier
    edge_rise_a: assert property (@(posedge i_mclk) disable iff (!i_arst_n) // R7
        pulse_edge |-> pulse_s2 && !$past(pulse_s2))
        else $error("edge without a low to high step");

endmodule

//--- sim/udc_src.sv
// far-side model: pulse source and another block's live values
`timescale 1ns/100ps
module udc_src (
    input  wire logic  i_mclk,    // system clock
    output logic        o_pulse,   // count pulse pin
    output logic [31:0] o_ref_set, // other block's set value
    output logic [31:0] o_ref_clr  // other block's clear value
);
    // idle levels at time zero
    initial begin
        o_pulse   = 1'b0;
        o_ref_set = 32'h0000_0000;
        o_ref_clr = 32'h0000_0000;
    end

    // each level held two clocks, else the synchroniser may miss it
    task automatic burst(input int n);
        repeat (n) begin
            @(posedge i_mclk);
            o_pulse <= 1'b1;
            repeat (2) @(posedge i_mclk);
            o_pulse <= 1'b0;
            repeat (2) @(posedge i_mclk);
        end
    endtask

    // new live values, changed right after an edge
    task automatic set_ref(input logic [31:0] s, input logic [31:0] c);
        @(posedge i_mclk);
        o_ref_set <= s;
        o_ref_clr <= c;
    endtask
endmodule

//--- sim/udc_counter_tb.sv
// self-checking bench for the up/down threshold counter
`timescale 1ns/100ps
module udc_counter_tb;
    import udc_pkg::*;
    localparam logic [31:0] TOP = 32'h0000_0014; // small ceiling keeps runs short
    logic        i_mclk, i_arst_n, i_dir, i_wipe, i_wr, i_rd, pulse, o_switch;
    logic [7:0]  i_addr;
    logic [31:0] i_wdata, o_rdata, o_count, ref_set, ref_clr;
    int          fail_count, compares;

    udc_src src (.i_mclk(i_mclk), .o_pulse(pulse), .o_ref_set(ref_set), .o_ref_clr(ref_clr));
    udc_counter #(.CNT_MIN(32'h0000_0000), .CNT_MAX(TOP)) dut (
        .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_pulse(pulse), .i_dir(i_dir), .i_wipe(i_wipe),
        .i_ref_set(ref_set), .i_ref_clr(ref_clr), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_count(o_count), .o_switch(o_switch));

    // clock generator
    initial begin
        i_mclk = 1'b0;
        forever #25 i_mclk = ~i_mclk;
    end

    task automatic end_of_test;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_mclk);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_mclk);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(negedge i_mclk);
        chk(o_rdata, e);
    endtask

    // pulses, then sync plus count plus switch latency has passed
    task automatic pulses(input int n, input logic [31:0] c, input logic s);
        src.burst(n);
        repeat (6) @(posedge i_mclk);
        @(negedge i_mclk);
        chk(o_count, c);
        chk({31'h0, o_switch}, {31'h0, s});
    endtask

    task automatic wipe(input logic v);
        @(posedge i_mclk);
        i_wipe <= v;
        repeat (6) @(posedge i_mclk);
    endtask

    task automatic t_reset;
        rd(OFS_CTRL, 32'h0000_0000);
        rd(OFS_START, RST_START);
        rd(OFS_SET, RST_SET);
        rd(OFS_CLEAR, RST_CLEAR);
        wr(OFS_COUNT, 32'h0000_0005);
        rd(OFS_COUNT, RST_COUNT);
        rd(8'hFC, 32'h0000_0000);
    endtask

    task automatic t_count;
        wr(OFS_SET, 32'h0000_0003);
        wr(OFS_CLEAR, 32'h0000_0001);
        pulses(2, 32'h0000_0002, 1'b0);
        pulses(1, 32'h0000_0003, 1'b1);
        @(posedge i_mclk);
        i_dir <= 1'b1;
        pulses(2, 32'h0000_0001, 1'b1);
        pulses(1, 32'h0000_0000, 1'b0);
        pulses(1, 32'h0000_0000, 1'b0);
        rd(OFS_COUNT, 32'h0000_0000);
        rd(OFS_STATUS, 32'h0000_0004);
    endtask

    task automatic t_wipe;
        wr(OFS_START, 32'h0000_0005);
        i_dir <= 1'b0;
        wipe(1'b1);
        pulses(3, 32'h0000_0005, 1'b0);
        rd(OFS_STATUS, 32'h0000_0002);
        wipe(1'b0);
        @(negedge i_mclk);
        chk(o_count, 32'h0000_0005);
        chk({31'h0, o_switch}, 32'h0000_0001);
    endtask

    // clamped live set level, then live clear level
    task automatic t_ref;
        src.set_ref(32'hFFFF_FFFF, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0003);
        rd(OFS_CTRL, 32'h0000_0003);
        wipe(1'b1);
        wipe(1'b0);
        pulses(14, 32'h0000_0013, 1'b0);
        pulses(1, TOP, 1'b1);
        pulses(1, TOP, 1'b1);
        src.set_ref(32'hFFFF_FFFF, 32'h0000_0013);
        @(posedge i_mclk);
        i_dir <= 1'b1;
        pulses(2, 32'h0000_0012, 1'b0);
    endtask

    // window mode: fixed set level below clear level
    task automatic t_window;
        wr(OFS_SET, 32'h0000_0010);
        wr(OFS_CLEAR, 32'h0000_0012);
        wr(OFS_CTRL, 32'h0000_0000);
        pulses(1, 32'h0000_0011, 1'b1);
        pulses(2, 32'h0000_000F, 1'b0);
    endtask

    // bound on the whole run
    initial begin
        repeat (20000) @(posedge i_mclk);
        fail_count++;
        end_of_test();
    end

    initial begin
        {i_arst_n, i_dir, i_wipe, i_wr, i_rd} = 5'h00;
        i_addr     = 8'h00;
        i_wdata    = 32'h0000_0000;
        fail_count = 0;
        compares   = 0;
        repeat (16) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        t_reset();
        t_count();
        t_wipe();
        t_ref();
        t_window();
        end_of_test();
    end
endmodule
